// [logic/wdt_defines.vh]
// constants for the watchdog, sleep and reset-cause block
// ==========================================================
// Summary of operation
// R1: watchdog counts its own oscillator tick or system clock divided by four.
// R2: with watchdog disabled, all watchdog instructions do nothing.
// R3: time-out divider is option-selected power of two, 2^12 to 2^15.
// R4: clears reset only last two divider stages; time-out 2^n to 2^(n+1). Code gives just over 2^(n-1) up to 2^n.
// R5: overflow in normal operation gives full chip reset and sets expiry flag.
// R6: overflow in sleep gives warm restart: program counter and stack pointer only.
// R7: count cleared by reset pin low, clear instruction, or sleep instruction.
// R8: single-clear mode uses one instruction; dual-clear needs both instructions.
// R9: with instruction clock source, watchdog stops counting during sleep.
// R10: sleep stops system clock; watchdog oscillator runs; state retained.
// R11: sleep entry clears watchdog, which restarts if on its own oscillator.
// R12: sleep instruction sets power-down flag and clears expiry flag.
// R13: power-down flag cleared by power-up or single clear instruction.
// R14: sleep exits on reset pin, interrupt, port A falling edge, overflow.
// R15: each port A bit selectable as wake source; resumes at next instruction.
// R16: interrupt wake takes vector if enabled and stack not full, else continues.
// R17: interrupt already pending before sleep cannot wake the device.
// R18: any wake-up waits 1024 system clocks before execution resumes.
// R19: start-up timer inserts 1024 system clocks at power-up.
// R20: flags encode cause: 00 power-up, 01 pin wake, 1u watchdog, 11 watchdog wake.
// R21: chip reset restarts program at zero with watchdog cleared and counting.
// R22: in RC oscillator mode clock output pin carries system clock divided by four.
// R23: expiry flag is status bit 5, power-down flag is status bit 4.
// R24: dual-clear accepts first and second instruction in either order.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define INSTR_DIV          4
`define WDT_CNT_W          16
`define WDT_SEL_W          2
`define WDT_MIN_EXP        12
`define STARTUP_CYCLES     1024
`define STARTUP_CNT_W      11
`define STATUS_EXPIRY_BIT  5
`define STATUS_PDOWN_BIT   4
`define PORTA_W            8
`endif

// [logic/wdt_counter.v]
// watchdog divider chain with selectable overflow tap
module wdt_counter (
  input  wire                  i_clk,
  input  wire                  i_rst_n,
  input  wire                  i_tick,
  input  wire                  i_clear,
  input  wire                  i_full_clear,
  input  wire [1:0]            i_sel,
  output reg                   o_overflow
);
`include "wdt_defines.vh"
  reg  [15:0] cnt_q;
  reg  [15:0] cnt_d;
  wire [4:0]  top_bit = 5'd12 + {3'b000, i_sel};
  reg         tap_prev_q;
  wire        tap = cnt_q[top_bit[3:0]];

  // ========================================================
  // divider chain
  always @* begin
    cnt_d = cnt_q;
    if (i_full_clear)
      cnt_d = 16'h0000;
    else if (i_clear) begin
      // only the last two stages clear, so period is just over 2^(n-1) up to 2^n R4
      cnt_d[top_bit[3:0]] = 1'b0;
      cnt_d[top_bit[3:0] - 4'd1] = 1'b0;
    end else if (i_tick)
      cnt_d = cnt_q + 16'h0001;
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q      <= 16'h0000;
      tap_prev_q <= 1'b0;
      o_overflow <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      tap_prev_q <= tap;
      // tap falling edge marks 2^(n+1) period wrap; tap rise marks 2^n R3
      o_overflow <= tap & ~tap_prev_q & ~i_clear & ~i_full_clear;
    end
  end
endmodule

// [logic/wdt_sleep_ctrl.v]
// watchdog, sleep entry and exit, start-up delay and reset-cause flags
module wdt_sleep_ctrl (
  input  wire        I_SYS_CLK,
  input  wire        I_RST_N,
  input  wire        I_POWER_UP,
  input  wire        I_EXTERNAL_RST_PIN_N,
  input  wire        I_OPT_WDT_ENABLE,
  input  wire        I_OPT_WDT_OSC_ENABLE,
  input  wire        I_OPT_WDT_SRC_OSC,
  input  wire [1:0]  I_OPT_WDT_DIV_SEL,
  input  wire        I_OPT_DUAL_CLEAR,
  input  wire        I_OPT_RC_OSC_MODE,
  input  wire [7:0]  I_OPT_PORTA_WAKE,
  input  wire        I_WDT_OSC_TICK,
  input  wire        I_SINGLE_CLEAR_INSTRUCTION,
  input  wire        I_FIRST_CLEAR_INSTRUCTION,
  input  wire        I_SECOND_CLEAR_INSTRUCTION,
  input  wire        I_SLEEP_INSTRUCTION,
  input  wire [7:0]  I_PORTA,
  input  wire        I_INT_REQ,
  input  wire        I_INT_ENABLE,
  input  wire        I_STACK_FULL,
  output reg         O_CHIP_RESET,
  output reg         O_WARM_RESTART,
  output reg         O_RUN,
  output reg         O_SLEEPING,
  output reg         O_SYS_CLK_EN,
  output reg         O_INT_VECTOR_TAKE,
  output reg         O_EXPIRY_FLAG,
  output reg         O_POWERDOWN_FLAG,
  output wire [7:0]  O_STATUS_FLAGS,
  output reg         O_CLOCK_OUT_PIN,
  output wire        O_CLOCK_OUT_PIN_OE
);
`include "wdt_defines.vh"

  localparam ST_STARTUP = 2'b00;
  localparam ST_RUN     = 2'b01;
  localparam ST_SLEEP   = 2'b10;
  localparam ST_WAKE    = 2'b11;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [10:0] sst_q;
  reg  [1:0]  div4_q;
  reg         int_pend_q;
  reg  [7:0]  porta_q;
  reg         first_seen_q;
  reg         second_seen_q;
  reg         take_vec_q;
  reg         pin_q;
  wire        wdt_overflow;

  // ========================================================
  // instruction clock divider and clock output pin
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      div4_q <= 2'b00;
    else if (O_SYS_CLK_EN)
      div4_q <= div4_q + 2'b01;
  end
  wire instr_tick = O_SYS_CLK_EN & (div4_q == 2'b11); // R1

  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      O_CLOCK_OUT_PIN <= 1'b0;
    else
      O_CLOCK_OUT_PIN <= div4_q[1]; // R22
  end
  assign O_CLOCK_OUT_PIN_OE = I_OPT_RC_OSC_MODE; // R22

  // ========================================================
  // clear instruction handling
  wire en = I_OPT_WDT_ENABLE; // R2
  wire running = (state_q == ST_RUN);
  wire single_clr = en & running & ~I_OPT_DUAL_CLEAR & I_SINGLE_CLEAR_INSTRUCTION; // R8
  wire first_now  = first_seen_q | I_FIRST_CLEAR_INSTRUCTION;
  wire second_now = second_seen_q | I_SECOND_CLEAR_INSTRUCTION;
  // either order accepted R24
  wire dual_clr = en & running & I_OPT_DUAL_CLEAR & first_now & second_now; // R8
  wire sleep_go = running & I_SLEEP_INSTRUCTION;

  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (dual_clr | O_CHIP_RESET) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (en & running & I_OPT_DUAL_CLEAR) begin
      first_seen_q  <= first_now;
      second_seen_q <= second_now;
    end
  end

  // ========================================================
  // watchdog counter
  wire use_osc = I_OPT_WDT_SRC_OSC & I_OPT_WDT_OSC_ENABLE;
  // instruction clock stops in sleep, so count halts there R9
  wire wdt_tick = en & (use_osc ? I_WDT_OSC_TICK : instr_tick); // R1
  wire pin_low = ~I_EXTERNAL_RST_PIN_N;
  // sleep entry clears and count restarts on its oscillator R11
  wire wdt_clr = single_clr | dual_clr | (en & sleep_go); // R7

  wdt_counter u_wdt (
    .i_clk        (I_SYS_CLK),
    .i_rst_n      (I_RST_N),
    .i_tick       (wdt_tick),
    .i_clear      (wdt_clr),
    .i_full_clear (pin_low | I_POWER_UP | O_CHIP_RESET), // R7 R21
    .i_sel        (I_OPT_WDT_DIV_SEL),
    .o_overflow   (wdt_overflow)
  );

  // ========================================================
  // wake sources
  wire [7:0] porta_fall = porta_q & ~I_PORTA & I_OPT_PORTA_WAKE; // R15
  // only a request that rises during sleep may wake R17
  wire int_wake = I_INT_REQ & ~int_pend_q;
  wire wake = (|porta_fall) | int_wake; // R14

  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      porta_q    <= 8'hFF;
      int_pend_q <= 1'b0;
    end else begin
      porta_q    <= I_PORTA;
      if (state_q != ST_SLEEP)
        int_pend_q <= I_INT_REQ; // R17
    end
  end

  // ========================================================
  // control state machine
  wire sst_done = (sst_q == 11'd1023);
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STARTUP: if (sst_done) state_d = ST_RUN; // R19
      ST_RUN:     if (sleep_go) state_d = ST_SLEEP;
      ST_SLEEP:   if (wake | (en & wdt_overflow)) state_d = ST_WAKE; // R14
      ST_WAKE:    if (sst_done) state_d = ST_RUN; // R18
      default:    state_d = ST_STARTUP;
    endcase
    if (pin_low | I_POWER_UP)
      state_d = ST_STARTUP;
    else if (en & wdt_overflow & running)
      state_d = ST_STARTUP; // R5
  end

  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q           <= ST_STARTUP;
      sst_q             <= 11'd0;
      O_CHIP_RESET      <= 1'b1;
      O_WARM_RESTART    <= 1'b0;
      O_INT_VECTOR_TAKE <= 1'b0;
      take_vec_q        <= 1'b0;
      pin_q             <= 1'b0;
    end else begin
      state_q        <= state_d;
      pin_q          <= pin_low;
      // held at zero while a reset source stands, so a long pin low cannot wrap it
      sst_q          <= (state_d != state_q || state_d == ST_RUN || state_d == ST_SLEEP ||
                         pin_low || I_POWER_UP) ? 11'd0 : sst_q + 11'd1; // R18 R19
      // chip reset: pc 000H, interrupts off, ports in, stack top R21
      O_CHIP_RESET   <= pin_low | I_POWER_UP | (en & wdt_overflow & running); // R5
      // warm restart only pc and stack pointer R6
      O_WARM_RESTART <= (state_q == ST_SLEEP) & en & wdt_overflow & ~wake & ~pin_low;
      if (state_q == ST_SLEEP && int_wake)
        take_vec_q <= I_INT_ENABLE & ~I_STACK_FULL; // R16
      else if (state_q == ST_SLEEP && wake)
        take_vec_q <= 1'b0; // R15
      O_INT_VECTOR_TAKE <= (state_q == ST_WAKE) & sst_done & take_vec_q; // R16
    end
  end

  always @* begin
    O_RUN        = (state_q == ST_RUN);
    O_SLEEPING   = (state_q == ST_SLEEP);
    O_SYS_CLK_EN = (state_q != ST_SLEEP); // R10
  end

  // ========================================================
  // reset-cause flags; set wins over a same-cycle clear except the power-up clear
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_EXPIRY_FLAG    <= 1'b0;
      O_POWERDOWN_FLAG <= 1'b0;
    end else if (I_POWER_UP) begin
      O_EXPIRY_FLAG    <= 1'b0; // R20
      O_POWERDOWN_FLAG <= 1'b0; // R13
    end else if (en & wdt_overflow & (running | (state_q == ST_SLEEP))) begin
      O_EXPIRY_FLAG    <= 1'b1; // R5 R20
    end else if (pin_low & ~pin_q & (state_q == ST_SLEEP)) begin
      O_EXPIRY_FLAG    <= 1'b0; // R20
      O_POWERDOWN_FLAG <= 1'b1;
    end else if (sleep_go) begin
      O_EXPIRY_FLAG    <= 1'b0; // R12
      O_POWERDOWN_FLAG <= 1'b1; // R12
    end else if (single_clr) begin
      O_EXPIRY_FLAG    <= 1'b0; // R23
      O_POWERDOWN_FLAG <= 1'b0; // R13
    end
  end

  assign O_STATUS_FLAGS = {2'b00, O_EXPIRY_FLAG, O_POWERDOWN_FLAG, 4'h0}; // R23
endmodule

// [verification/wdt_core_model.sv]
// processor core stand-in that issues watchdog clear instructions
module wdt_core_model (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [1:0] mode,
  output logic            single_clr = 1'b0,
  output logic            first_clr = 1'b0,
  output logic            second_clr = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cnt = 9'h000;
  // ==========================================
  // clear issue
  // gated on run: a halted core executes nothing
  // mode 3 sends the first half only, a deliberately broken pair
  always @(posedge clk) begin
    cnt <= cnt + 9'h001;
    single_clr <= run && mode == 2'h1 && cnt == 9'h1FF;
    first_clr <= run && mode[1] && cnt == 9'h1FE;
    second_clr <= run && mode == 2'h2 && cnt == 9'h1FF;
  end
endmodule

// [verification/wdt_sleep_ctrl_assertions.sv]
// concurrent checks for the watchdog, sleep and reset-cause block
module wdt_sleep_ctrl_assertions (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_EXTERNAL_RST_PIN_N,
  input wire logic I_OPT_WDT_ENABLE,
  input wire logic I_OPT_DUAL_CLEAR,
  input wire logic I_SINGLE_CLEAR_INSTRUCTION,
  input wire logic I_SLEEP_INSTRUCTION,
  input wire logic O_CHIP_RESET,
  input wire logic O_WARM_RESTART,
  input wire logic O_RUN,
  input wire logic O_SLEEPING,
  input wire logic O_SYS_CLK_EN,
  input wire logic O_EXPIRY_FLAG,
  input wire logic O_POWERDOWN_FLAG,
  input wire logic O_CLOCK_OUT_PIN
);
  // ==========================================
  // helper: cycles since the last sleep, run or pin-low cycle
  // a 1024-cycle window is too long for a delay range
  logic [10:0] delay_cnt;
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      delay_cnt <= 11'h000;
    else if (O_SLEEPING || O_RUN || !I_EXTERNAL_RST_PIN_N)
      delay_cnt <= 11'h000;
    else
      delay_cnt <= delay_cnt + 11'h001;
  end
  // ==========================================
  // properties
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_woken; $fell(O_SLEEPING) && !O_CHIP_RESET; endsequence
  sequence s_hold; !O_RUN [*8]; endsequence
  property p_wake; s_woken |-> s_hold; endproperty
  a_wake: assert property (p_wake) else $error("wake delay wrong");
  property p_delay; $rose(O_RUN) |-> delay_cnt == 11'h400; endproperty
  a_delay: assert property (p_delay) else $error("start-up delay wrong");
  property p_sleep; I_SLEEP_INSTRUCTION && O_RUN |=>
    O_SLEEPING && O_POWERDOWN_FLAG && !O_EXPIRY_FLAG; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_clkoff; O_SLEEPING |-> !O_SYS_CLK_EN && !O_RUN; endproperty
  a_clkoff: assert property (p_clkoff) else $error("clock runs in sleep");
  property p_clkout; $rose(O_CLOCK_OUT_PIN) && O_RUN |=>
    O_CLOCK_OUT_PIN ##1 !O_CLOCK_OUT_PIN; endproperty
  a_clkout: assert property (p_clkout) else $error("clock out not div 4");
  property p_warm; O_WARM_RESTART |->
    $past(O_SLEEPING) ##[0:1] (O_EXPIRY_FLAG && O_POWERDOWN_FLAG); endproperty
  a_warm: assert property (p_warm) else $error("warm restart wrong");
  property p_pin; !I_EXTERNAL_RST_PIN_N |=> O_CHIP_RESET && !O_RUN; endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_clear; I_SINGLE_CLEAR_INSTRUCTION && O_RUN && I_OPT_WDT_ENABLE &&
    !I_OPT_DUAL_CLEAR |=> !O_POWERDOWN_FLAG && !O_EXPIRY_FLAG; endproperty
  a_clear: assert property (p_clear) else $error("clear kept flags");
  property p_off; !I_OPT_WDT_ENABLE && !O_EXPIRY_FLAG |=> !O_EXPIRY_FLAG; endproperty
  a_off: assert property (p_off) else $error("disabled watchdog expired");
endmodule
bind wdt_sleep_ctrl wdt_sleep_ctrl_assertions u_wdt_sleep_ctrl_assertions (.*);

// [verification/testbench.sv]
// self-checking bench for the watchdog, sleep and reset-cause block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, wen = 1'b1, dual = 1'b0;
  logic sleep = 1'b0, ireq = 1'b0, ien = 1'b0, sfull = 1'b0, vec = 1'b0;
  logic src = 1'b1, rcm = 1'b1;
  wire oe;
  logic [7:0] pwake = 8'h00, pa = 8'hFF;
  logic [1:0] mode = 2'h0;
  logic [19:0] r;
  int err_count = 0, total_checks = 0, cyc = 0, nrst = 0, n = 0;
  wire chip, warm, run, slp, vtake, sc, fc, tc;
  wire [7:0] stat;
  wire [2:0] ev = {warm, chip, run};
  // wake mask, port level, request, enable, stack full, vector expected
  logic [19:0] rows [5] = '{20'h01FE0, 20'h807F0, 20'h00FFD, 20'h00FFE, 20'h00FF8};
  wdt_sleep_ctrl u_wdt_sleep_ctrl (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_POWER_UP(1'b0), .I_EXTERNAL_RST_PIN_N(pin_n),
    .I_OPT_WDT_ENABLE(wen), .I_OPT_WDT_OSC_ENABLE(1'b1), .I_OPT_WDT_SRC_OSC(src),
    .I_OPT_WDT_DIV_SEL(2'h0), .I_OPT_DUAL_CLEAR(dual), .I_OPT_RC_OSC_MODE(rcm),
    .I_OPT_PORTA_WAKE(pwake), .I_WDT_OSC_TICK(1'b1), .I_SINGLE_CLEAR_INSTRUCTION(sc),
    .I_FIRST_CLEAR_INSTRUCTION(fc), .I_SECOND_CLEAR_INSTRUCTION(tc),
    .I_SLEEP_INSTRUCTION(sleep), .I_PORTA(pa), .I_INT_REQ(ireq), .I_INT_ENABLE(ien),
    .I_STACK_FULL(sfull), .O_CHIP_RESET(chip), .O_WARM_RESTART(warm), .O_RUN(run),
    .O_SLEEPING(slp), .O_SYS_CLK_EN(), .O_INT_VECTOR_TAKE(vtake), .O_EXPIRY_FLAG(),
    .O_POWERDOWN_FLAG(), .O_STATUS_FLAGS(stat), .O_CLOCK_OUT_PIN(), .O_CLOCK_OUT_PIN_OE(oe));
  wdt_core_model u_wdt_core_model (.clk(clk), .run(run), .mode(mode), .single_clr(sc),
    .first_clr(fc), .second_clr(tc));
  initial forever #25 clk = ~clk;
  // run takes about 43000 cycles
  always @(posedge clk) begin
    cyc++;
    if (chip === 1'b1 && rst_n === 1'b1) nrst++;
    if (vtake === 1'b1) vec = 1'b1;
    if (cyc == 80000) begin
      err_count++;
      test_done();
    end
  end
  // ==========================================
  // tasks
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task flg(input logic [7:0] e);
    chk("status", e, stat);
  endtask
  task wait_ev(input int b);
    n = 0;
    while (ev[b] !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n == 9000) chk("wait", 8'h01, 8'h00);
  endtask
  task resume();
    wait_ev(0);
    chk("delay", 8'h01, {7'h0, n > 1023 && n < 1031});
  endtask
  // core stops clearing first so no clear meets the sleep edge
  task go_sleep();
    mode <= 2'h0;
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    @(posedge clk);
    flg(8'h10);
    chk("asleep", 8'h01, {7'h0, slp});
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    resume();
    flg(8'h00);
    chk("clock out oe", 8'h01, {7'h0, oe});
    rcm <= 1'b0;
    @(posedge clk);
    chk("clock out oe", 8'h00, {7'h0, oe});
    rcm <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      pwake <= r[19:12];
      go_sleep();
      {pa, ireq, ien, sfull} <= r[11:1];
      vec = 1'b0;
      resume();
      {pa, ireq} <= 9'h1FE;
      mode <= 2'h1;
      repeat (600) @(posedge clk);
      chk("vector", {7'h0, r[0]}, {7'h0, vec});
      flg(8'h00);
    end
    go_sleep();
    wait_ev(2);
    wait_ev(0);
    flg(8'h30);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    resume();
    flg(8'h30);
    {ireq, ien, pwake} <= 10'h301;
    go_sleep();
    pa <= 8'hFD;
    repeat (50) @(posedge clk);
    chk("asleep", 8'h01, {7'h0, slp});
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    {pin_n, pa, ireq} <= 10'h3FE;
    resume();
    flg(8'h10);
    {dual, mode} <= 3'h6;
    nrst = 0;
    repeat (9000) @(posedge clk);
    chk("resets", 8'h00, nrst[7:0]);
    mode <= 2'h3;
    wait_ev(1);
    resume();
    flg(8'h30);
    {dual, mode} <= 3'h1;
    repeat (600) @(posedge clk);
    {wen, mode} <= 3'h0;
    nrst = 0;
    repeat (9000) @(posedge clk);
    chk("resets", 8'h00, nrst[7:0]);
    // instruction clock source: no tick while asleep, so no overflow wake
    {wen, src, mode} <= 4'h9;
    repeat (600) @(posedge clk);
    go_sleep();
    repeat (5000) @(posedge clk);
    chk("asleep", 8'h01, {7'h0, slp});
    test_done();
  end
endmodule
